// [logic/shs_sequencer.sv]
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - halt-all stops channels, then clears command
// - normal start runs masked channels, then clears
// - start failures flagged per channel in faults
// - unit numbers readable only until first trigger
// - trigger failures flagged per channel in faults
// - trigger runs transfers on masked channels only
// - trigger completes within bound or times out
// - outputs are 48 bits across words 0,1
// - inputs same layout; control word shows fault bytes
// - all channels idle after reset or halt
// - setup start opens remote parameter pass-through
// - remote read returns right-aligned data in word0
// - read codes pick byte, word, long, double width
// - write codes pick width of supplied data
// - pass-through failure sets channel fault bit
// - setup start presents descriptor pointer in word2
module shs_sequencer #(
	parameter int unsigned XFER_BOUND_CYC  = shs_pkg::XFER_BOUND_CYC,
	parameter int unsigned START_BOUND_CYC = shs_pkg::START_BOUND_CYC
) (
	input  wire logic                         ref_clk,
	input  wire logic                         resetn,
	input  wire logic [shs_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [shs_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic                              rem_halt,
	output logic                              rem_req_valid,
	input  wire logic                         rem_req_ready,
	output logic [shs_pkg::CHW-1:0]           rem_req_chan,
	output shs_pkg::shs_op_t                  rem_req_op,
	output logic [31:0]                       rem_req_ctl,
	output logic [31:0]                       rem_req_w0,
	output logic [31:0]                       rem_req_w1,
	input  wire logic                         rem_rsp_valid,
	output logic                              rem_rsp_ready,
	input  wire logic                         rem_rsp_err,
	input  wire logic [31:0]                  rem_rsp_w0,
	input  wire logic [31:0]                  rem_rsp_w1,
	input  wire logic [31:0]                  rem_rsp_w2,
	input  wire logic [7:0]                   rem_rsp_unit,
	input  wire logic [7:0]                   rem_rsp_near_fault_byte,
	input  wire logic [7:0]                   rem_rsp_status_byte,
	input  wire logic [7:0]                   rem_rsp_link_state_byte,
	input  wire logic [7:0]                   rem_rsp_far_fault_byte
);
	import shs_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		shs_seq_st_t          st;
		logic [15:0]          cmd;
		shs_op_t              op;
		logic [NCH-1:0]       pend;
		logic [CHW-1:0]       chan;
		logic [NCH-1:0]       active;
		logic                 setup;
		logic [NCH-1:0]       fault;
		logic [NCH-1:0][7:0]  unit;
		logic                 unit_ok;
		logic [1:0]           idx;
		logic [2:0][31:0]     obuf;
		logic [3:0][31:0]     rsp;
		logic [23:0]          tmo;
		logic                 aw_ok;
		logic [7:0]           awa;
		logic                 w_ok;
		logic [31:0]          wd;
		logic [3:0]           ws;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic [1:0]           rph;
		logic [7:0]           ara;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
	} shs_state_t;

	shs_state_t      st_q;
	shs_state_t      st_d;
	logic [31:0]     out_rd;
	logic [31:0]     in_rd;
	logic            out_we;

	// ****************************************
	// Channel word stores
	// ****************************************
	// Host-written words feed requests; remote answers land in a second
	// store so a host write never clobbers fresh input data.
	assign out_we = st_q.aw_ok && st_q.w_ok && !st_q.bvalid && st_q.awa[CHAN_AREA_BIT];

	shs_word_ram #(
		.DW (32),
		.AW (RAM_AW)
	) u_out_ram (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr_en   (out_we),
		.wr_be   (st_q.ws),
		.wr_addr (st_q.awa[6:2]),
		.wr_data (st_q.wd),
		.rd_addr ({st_q.chan, st_q.idx}),
		.rd_data (out_rd)
	);

	shs_word_ram #(
		.DW (32),
		.AW (RAM_AW)
	) u_in_ram (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr_en   (st_q.st == S_STORE),
		.wr_be   (4'hf),
		.wr_addr ({st_q.chan, st_q.idx}),
		.wr_data (st_q.rsp[st_q.idx]),
		.rd_addr (st_q.ara[6:2]),
		.rd_data (in_rd)
	);

	// ****************************************
	// Sequencer and register slave
	// ****************************************
	always_comb begin
		logic [7:0]     code;
		logic [31:0]    wmask;
		logic [NCH-1:0] ch_bit;
		logic [CHW-1:0] low;
		logic           busy;
		logic           starting;
		logic           code_ok;
		logic [23:0]    tmo_lim;
		logic [15:0]    wv;
		logic [7:0]     wmask_ch;
		code = st_q.obuf[0][31:24];
		wmask = shs_width_mask(code[1:0]);
		ch_bit = '0;
		ch_bit[st_q.chan] = 1'b1;
		low = shs_lowest(st_q.pend);
		busy = !(st_q.st inside {S_IDLE, S_HALT});
		starting = st_q.op inside {OP_START_NORM, OP_START_SETUP};
		code_ok = (code[7:2] == REM_RD_BYTE[7:2]) || (code[7:2] == REM_WR_BYTE[7:2]);
		tmo_lim = starting ? 24'(START_BOUND_CYC) : 24'(XFER_BOUND_CYC);
		wv = st_q.cmd;
		wmask_ch = '0;
		st_d = st_q;
		if (busy) begin
			st_d.tmo = st_q.tmo + 24'h1;
		end

		case (st_q.st)
			S_IDLE: begin
			end
			S_HALT: begin
				st_d.cmd = RST_CMD;
				st_d.st = S_IDLE;
			end
			S_NEXT: begin
				if (st_q.pend == '0) begin
					st_d.cmd = RST_CMD;
					st_d.st = S_IDLE;
				end else begin
					st_d.chan = low;
					st_d.pend[low] = 1'b0;
					st_d.idx = '0;
					st_d.obuf = '0;
					if (starting) begin
						st_d.st = S_ISSUE;
					end else if (!st_q.active[low]) begin
						// Idle channel cannot transfer
						st_d.fault[low] = 1'b1;
					end else begin
						st_d.st = S_FETCH;
					end
				end
			end
			S_FETCH: begin
				st_d.idx = st_q.idx + 2'h1;
				if (st_q.idx != 2'h0) begin
					st_d.obuf[st_q.idx - 2'h1] = out_rd;
				end
				if (st_q.idx == WORD_IF2) begin
					st_d.st = S_ISSUE;
					if (st_q.op == OP_PARAM) begin
						// Width of supplied write data follows the code
						st_d.obuf[1] = st_q.obuf[1] & wmask;
						st_d.obuf[2] = (code[1:0] == REM_WIDTH_DBL) ? out_rd : 32'h0;
						if (!code_ok) begin
							st_d.fault[st_q.chan] = 1'b1;
							st_d.st = S_NEXT;
						end
					end else begin
						st_d.obuf[2] = out_rd & IF1_PD_MASK;
					end
				end
			end
			S_ISSUE: begin
				if (rem_req_ready) begin
					st_d.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (rem_rsp_valid) begin
					st_d.rsp[0] = {rem_rsp_far_fault_byte, rem_rsp_link_state_byte,
						rem_rsp_status_byte, rem_rsp_near_fault_byte};
					st_d.rsp[1] = rem_rsp_w0;
					st_d.rsp[2] = rem_rsp_w1;
					st_d.rsp[3] = rem_rsp_w2;
					if (st_q.op == OP_PARAM) begin
						st_d.rsp[1] = rem_rsp_w0 & wmask;
						if (code[1:0] != REM_WIDTH_DBL) begin
							st_d.rsp[2] = 32'h0;
						end
					end else if (st_q.op == OP_XFER_PD) begin
						st_d.rsp[2] = rem_rsp_w1 & IF1_PD_MASK;
					end
					if (rem_rsp_err) begin
						// Start, transfer and pass-through failures alike
						st_d.fault[st_q.chan] = 1'b1;
					end else if (starting) begin
						st_d.active[st_q.chan] = 1'b1;
					end
					if (starting) begin
						st_d.unit[st_q.chan] = rem_rsp_unit;
					end
					st_d.idx = '0;
					st_d.st = S_STORE;
				end
			end
			S_STORE: begin
				st_d.idx = st_q.idx + 2'h1;
				// Only a start rewrites the pointer word
				if (st_q.idx == WORD_IF2 || (st_q.idx == WORD_IF1 && !starting)) begin
					st_d.st = S_NEXT;
				end
			end
			default: begin
				st_d.st = S_IDLE;
			end
		endcase

		// A silent remote must not hang the command word forever
		if (busy && st_q.tmo >= tmo_lim) begin
			st_d.fault = st_q.fault | st_q.pend | ((st_q.st == S_NEXT) ? '0 : ch_bit);
			st_d.pend = '0;
			st_d.cmd = RST_CMD;
			st_d.st = S_IDLE;
		end

		// ****************************************
		// Write channels
		// ****************************************
		if (s_axi_awvalid && !st_q.aw_ok && !st_q.bvalid) begin
			st_d.aw_ok = 1'b1;
			st_d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.w_ok && !st_q.bvalid) begin
			st_d.w_ok = 1'b1;
			st_d.wd = s_axi_wdata;
			st_d.ws = s_axi_wstrb;
		end
		if (st_q.aw_ok && st_q.w_ok && !st_q.bvalid) begin
			st_d.aw_ok = 1'b0;
			st_d.w_ok = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			if (st_q.awa[CHAN_AREA_BIT]) begin
			end else if (st_q.awa == ADDR_CMD) begin
				if (st_q.ws[0]) begin
					wv[7:0] = st_q.wd[7:0];
				end
				if (st_q.ws[1]) begin
					wv[15:8] = st_q.wd[15:8];
				end
				wmask_ch = wv[7:0];
				if (wv[CMD_IGNORE_BIT]) begin
					// Flagged write leaves command state alone
				end else if (wv[15:8] == CMD_HALT_ALL) begin
					// Halt preempts anything in flight
					st_d.cmd = wv;
					st_d.st = S_HALT;
					st_d.pend = '0;
					st_d.active = '0;
					st_d.setup = 1'b0;
				end else if (st_q.cmd == RST_CMD && st_q.st == S_IDLE) begin
					st_d.tmo = '0;
					st_d.pend = wmask_ch;
					if (wv[15:8] == CMD_START_NORM || wv[15:8] == CMD_START_SETUP) begin
						st_d.cmd = wv;
						st_d.st = S_NEXT;
						st_d.fault = '0;
						st_d.active = st_q.active & ~wmask_ch;
						st_d.setup = (wv[15:8] == CMD_START_SETUP);
						st_d.op = st_d.setup ? OP_START_SETUP : OP_START_NORM;
						st_d.unit_ok = 1'b1;
					end else if (wv[15:8] == CMD_TRIGGER) begin
						st_d.cmd = wv;
						st_d.st = S_NEXT;
						st_d.fault = '0;
						st_d.op = st_q.setup ? OP_PARAM : OP_XFER_PD;
						st_d.unit_ok = 1'b0;
					end else begin
						st_d.pend = '0;
					end
				end
			end else if (st_q.awa == ADDR_FAULT || st_q.awa == ADDR_UNIT_LO
					|| st_q.awa == ADDR_UNIT_HI) begin
			end else begin
				st_d.bresp = RESP_SLVERR;
			end
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// ****************************************
		// Read channels
		// ****************************************
		// Three-cycle read: one edge to capture the address, one to address the input store, one to load
		case (st_q.rph)
			2'h0: begin
				if (s_axi_arvalid && !st_q.rvalid) begin
					st_d.ara = s_axi_araddr;
					st_d.rph = 2'h1;
				end
			end
			2'h1: begin
				st_d.rph = 2'h2;
			end
			default: begin
				st_d.rph = 2'h0;
				st_d.rvalid = 1'b1;
				st_d.rresp = RESP_OKAY;
				st_d.rdata = 32'h0;
				if (st_q.ara[CHAN_AREA_BIT]) begin
					st_d.rdata = in_rd;
				end else if (st_q.ara == ADDR_CMD) begin
					st_d.rdata = {16'h0, st_q.cmd};
				end else if (st_q.ara == ADDR_FAULT) begin
					st_d.rdata = {24'h0, st_q.fault};
				end else if (st_q.ara == ADDR_UNIT_LO) begin
					st_d.rdata = st_q.unit_ok ? st_q.unit[3:0] : 32'h0;
				end else if (st_q.ara == ADDR_UNIT_HI) begin
					st_d.rdata = st_q.unit_ok ? st_q.unit[7:4] : 32'h0;
				end else begin
					st_d.rresp = RESP_SLVERR;
				end
			end
		endcase
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.st <= S_IDLE;
			st_q.op <= OP_START_NORM;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready = !st_q.aw_ok && !st_q.bvalid;
	assign s_axi_wready  = !st_q.w_ok && !st_q.bvalid;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = (st_q.rph == 2'h0) && !st_q.rvalid;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;
	assign rem_halt      = st_q.st == S_HALT;
	assign rem_req_valid = st_q.st == S_ISSUE;
	assign rem_req_chan  = st_q.chan;
	assign rem_req_op    = st_q.op;
	assign rem_req_ctl   = st_q.obuf[0];
	assign rem_req_w0    = st_q.obuf[1];
	assign rem_req_w1    = st_q.obuf[2];
	assign rem_rsp_ready = st_q.st == S_WAIT;

endmodule // shs_sequencer
`default_nettype wire

// [logic/shs_pkg.sv]
`default_nettype none
package shs_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int unsigned NCH     = 8;
	localparam int unsigned CHW     = 3;
	localparam int unsigned AXI_AW  = 8;
	localparam int unsigned RAM_AW  = 5;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_FAULT   = 8'h04;
	localparam logic [7:0] ADDR_UNIT_LO = 8'h08;
	localparam logic [7:0] ADDR_UNIT_HI = 8'h0c;
	localparam int unsigned CHAN_AREA_BIT = 7;
	localparam logic [1:0] WORD_CTL = 2'h0;
	localparam logic [1:0] WORD_IF0 = 2'h1;
	localparam logic [1:0] WORD_IF1 = 2'h2;
	localparam logic [1:0] WORD_IF2 = 2'h3;
	localparam logic [15:0] RST_CMD = 16'h0000;

	// ****************************************
	// Command word fields and codes
	// ****************************************
	localparam int unsigned CMD_IGNORE_BIT = 14;
	localparam logic [7:0] CMD_HALT_ALL    = 8'h08;
	localparam logic [7:0] CMD_START_NORM  = 8'h09;
	localparam logic [7:0] CMD_START_SETUP = 8'h0f;
	localparam logic [7:0] CMD_TRIGGER     = 8'h10;
	localparam logic [7:0] REM_RD_BYTE     = 8'h44;
	localparam logic [7:0] REM_WR_BYTE     = 8'h64;
	localparam logic [1:0] REM_WIDTH_DBL   = 2'h3;
	localparam logic [31:0] IF1_PD_MASK    = 32'h0000_ffff;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned XFER_BOUND_US  = 100;
	localparam int unsigned START_BOUND_MS = 10;
	localparam int unsigned XFER_BOUND_CYC  = XFER_BOUND_US * CLK_MHZ;
	localparam int unsigned START_BOUND_CYC = START_BOUND_MS * 1000 * CLK_MHZ;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		OP_START_NORM  = 2'h0,
		OP_START_SETUP = 2'h1,
		OP_XFER_PD     = 2'h2,
		OP_PARAM       = 2'h3
	} shs_op_t;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_HALT  = 7'h02,
		S_NEXT  = 7'h04,
		S_FETCH = 7'h08,
		S_ISSUE = 7'h10,
		S_WAIT  = 7'h20,
		S_STORE = 7'h40
	} shs_seq_st_t;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [31:0] shs_width_mask(input logic [1:0] w);
		case (w)
			2'h0: shs_width_mask = 32'h0000_00ff;
			2'h1: shs_width_mask = 32'h0000_ffff;
			default: shs_width_mask = 32'hffff_ffff;
		endcase
	endfunction

	function automatic logic [CHW-1:0] shs_lowest(input logic [NCH-1:0] m);
		shs_lowest = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (m[i]) begin
				shs_lowest = CHW'(i);
			end
		end
	endfunction

endpackage
`default_nettype wire

// [logic/shs_word_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module shs_word_ram #(
	parameter int unsigned DW = 32,
	parameter int unsigned AW = 5
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              wr_en,
	input  wire logic [DW/8-1:0]   wr_be,
	input  wire logic [AW-1:0]     wr_addr,
	input  wire logic [DW-1:0]     wr_data,
	input  wire logic [AW-1:0]     rd_addr,
	output logic      [DW-1:0]     rd_data
);

	typedef struct packed {
		logic [2**AW-1:0][DW-1:0] mem;
		logic [DW-1:0]            rd;
	} shs_ram_t;

	shs_ram_t st_q;
	shs_ram_t st_d;

	// Read returns the old word on a same-address write
	always_comb begin
		st_d = st_q;
		st_d.rd = st_q.mem[rd_addr];
		for (int b = 0; b < DW / 8; b++) begin
			if (wr_en && wr_be[b]) begin
				st_d.mem[wr_addr][b*8 +: 8] = wr_data[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rd;

endmodule // shs_word_ram
`default_nettype wire

// [verif/shs_sequencer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module shs_sequencer_checker
	import shs_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              rem_halt,
	input wire logic              rem_req_valid,
	input wire logic              rem_req_ready,
	input wire shs_pkg::shs_op_t  rem_req_op,
	input wire logic [31:0]       rem_req_ctl,
	input wire logic [31:0]       rem_req_w0,
	input wire logic [31:0]       rem_req_w1
);
	import shs_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	property p_halt_pulse;
		rem_halt |=> !rem_halt;
	endproperty
	a_halt_pulse: assert property (p_halt_pulse) else $error("halt pulse too long");
	property p_halt_idle;
		rem_halt |-> !rem_req_valid ##1 !rem_req_valid;
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("request during halt");
	property p_reset_idle;
		$rose(resetn) |-> !rem_req_valid && !rem_halt;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
	property p_req_hold;
		rem_req_valid && !rem_req_ready |=> rem_halt || (rem_req_valid
			&& $stable(rem_req_ctl) && $stable(rem_req_w0) && $stable(rem_req_op));
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request changed early");
	property p_param_code;
		rem_req_valid && rem_req_op == OP_PARAM |-> rem_req_ctl[31:26] inside {6'h11, 6'h19};
	endproperty
	a_param_code: assert property (p_param_code) else $error("bad remote code");
	property p_byte_width;
		rem_req_valid && rem_req_op == OP_PARAM && rem_req_ctl[25:24] == 2'h0
			|-> rem_req_w0[31:8] == 24'h0;
	endproperty
	a_byte_width: assert property (p_byte_width) else $error("byte data too wide");
	property p_word_width;
		rem_req_valid && rem_req_op == OP_PARAM && rem_req_ctl[25:24] == 2'h1
			|-> rem_req_w0[31:16] == 16'h0;
	endproperty
	a_word_width: assert property (p_word_width) else $error("word data too wide");
	property p_pd_high;
		rem_req_valid && rem_req_op == OP_XFER_PD |-> rem_req_w1[31:16] == 16'h0;
	endproperty
	a_pd_high: assert property (p_pd_high) else $error("unused output bytes set");
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read response late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // shs_sequencer_checker

bind shs_sequencer shs_sequencer_checker u_chk (.*);
`default_nettype wire

// [verif/shs_remote_model.sv]
`timescale 1ns/1ps
`default_nettype none
module shs_remote_model
	import shs_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              slow,
	input wire logic [7:0]        err_mask,
	input wire logic              rem_halt,
	input wire logic              rem_req_valid,
	output var logic              rem_req_ready,
	input wire logic [2:0]        rem_req_chan,
	input wire shs_pkg::shs_op_t  rem_req_op,
	input wire logic [31:0]       rem_req_ctl,
	input wire logic [31:0]       rem_req_w0,
	input wire logic [31:0]       rem_req_w1,
	output var logic              rem_rsp_valid,
	input wire logic              rem_rsp_ready,
	output logic                  rem_rsp_err,
	output logic [31:0]           rem_rsp_w0,
	output logic [31:0]           rem_rsp_w1,
	output logic [31:0]           rem_rsp_w2,
	output logic [7:0]            rem_rsp_unit,
	output logic [7:0]            rem_rsp_near_fault_byte,
	output logic [7:0]            rem_rsp_status_byte,
	output logic [7:0]            rem_rsp_link_state_byte,
	output logic [7:0]            rem_rsp_far_fault_byte
);
	logic [2:0]   ph;
	int           cnt;
	logic         err_q;
	logic [31:0]  w0_q, w1_q, w2_q;
	logic [7:0]   unit_q;

	// Outside a response the lines show the inverse, so stale data never matches
	assign rem_rsp_err = rem_rsp_valid ? err_q : ~err_q;
	assign rem_rsp_w0 = rem_rsp_valid ? w0_q : ~w0_q;
	assign rem_rsp_w1 = rem_rsp_valid ? w1_q : ~w1_q;
	assign rem_rsp_w2 = rem_rsp_valid ? w2_q : ~w2_q;
	assign rem_rsp_unit = rem_rsp_valid ? unit_q : ~unit_q;
	assign rem_rsp_near_fault_byte = rem_rsp_valid ? 8'h11 : 8'hee;
	assign rem_rsp_status_byte = rem_rsp_valid ? 8'h22 : 8'hdd;
	assign rem_rsp_link_state_byte = rem_rsp_valid ? 8'h33 : 8'hcc;
	assign rem_rsp_far_fault_byte = rem_rsp_valid ? 8'h44 : 8'hbb;

	// A halt abandons whatever is in flight
	always @(posedge ref_clk) begin
		if (!resetn || rem_halt) begin
			ph <= 3'h0;
			rem_req_ready <= 1'b0;
			rem_rsp_valid <= 1'b0;
		end else begin
			case (ph)
			3'h0: begin
				cnt <= slow ? 5 : 0;
				if (rem_req_valid) ph <= 3'h1;
			end
			3'h1: begin
				cnt <= cnt - 1;
				if (cnt == 0) begin
					rem_req_ready <= 1'b1;
					ph <= 3'h2;
				end
			end
			3'h2: begin
				rem_req_ready <= 1'b0;
				err_q <= err_mask[rem_req_chan];
				w0_q <= (rem_req_op == OP_PARAM) ? {rem_req_ctl[15:0], ~rem_req_ctl[15:0]}
					: ~rem_req_w0;
				w1_q <= ~rem_req_w1;
				w2_q <= {24'h000001, 5'h00, rem_req_chan};
				unit_q <= {5'h04, rem_req_chan};
				cnt <= slow ? 7 : 0;
				ph <= 3'h3;
			end
			3'h3: begin
				cnt <= cnt - 1;
				if (cnt == 0) begin
					rem_rsp_valid <= 1'b1;
					ph <= 3'h4;
				end
			end
			default: begin
				if (rem_rsp_ready) begin
					rem_rsp_valid <= 1'b0;
					ph <= 3'h0;
				end
			end
			endcase
		end
	end
endmodule // shs_remote_model
`default_nettype wire

// [verif/shs_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module shs_sequencer_bench;
	import shs_pkg::*;
	logic            ref_clk = 1'b0;
	logic            resetn, slow, rem_halt, rem_req_valid, rem_req_ready;
	logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic            s_axi_rvalid, s_axi_rready, rem_rsp_valid, rem_rsp_ready, rem_rsp_err;
	logic [1:0]      s_axi_bresp, s_axi_rresp, rr;
	logic [3:0]      s_axi_wstrb;
	logic [7:0]      s_axi_awaddr, s_axi_araddr, err_mask, rem_rsp_unit;
	logic [7:0]      rem_rsp_near_fault_byte, rem_rsp_status_byte;
	logic [7:0]      rem_rsp_link_state_byte, rem_rsp_far_fault_byte;
	logic [CHW-1:0]  rem_req_chan;
	shs_op_t         rem_req_op;
	logic [31:0]     s_axi_wdata, s_axi_rdata, rem_req_ctl, rem_req_w0, rem_req_w1, rv;
	logic [31:0]     rem_rsp_w0, rem_rsp_w1, rem_rsp_w2;
	int              n_errors = 0;
	int              total_checks = 0;
	int              cyc = 0;

	shs_sequencer #(.XFER_BOUND_CYC(200), .START_BOUND_CYC(500)) dut (.*);
	shs_remote_model remote (.*);

	always #4 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude;
		if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
		rd(a);
		chk(nm, e, rv);
	endtask

	// Command completion is seen as the command word reading zero
	task automatic cmd(input logic [31:0] d);
		int n;
		n = 0;
		wr(ADDR_CMD, d);
		rd(ADDR_CMD);
		while (rv !== 32'h0 && n < 500) begin
			rd(ADDR_CMD);
			n++;
		end
		chk("command", 32'h0, rv);
	endtask

	function automatic logic [31:0] wmask(input logic [1:0] w);
		return (w == 2'h0) ? 32'h0000_00ff : (w == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_idle;
		rdc(ADDR_FAULT, "fault", 32'h0);
		rdc(ADDR_UNIT_LO, "unit", 32'h0);
		rd(8'h10);
		chk("resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		wr(8'h10, 32'h0);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		cmd(32'h0000_1001);
		rdc(ADDR_FAULT, "fault", 32'h1);
	endtask

	task automatic t_start;
		cmd(32'h0000_0800);
		err_mask <= 8'h04;
		cmd(32'h0000_0905);
		rdc(ADDR_FAULT, "fault", 32'h4);
		rd(ADDR_UNIT_LO);
		chk("unit0", 32'h20, {24'h0, rv[7:0]});
	endtask

	task automatic t_trigger;
		wr(8'h84, 32'h1234_5678);
		wr(8'h88, 32'habcd_ef01);
		wr(ADDR_CMD, 32'h0000_1001);
		cmd(32'h0000_1004);
		rdc(ADDR_FAULT, "fault", 32'h0);
		rdc(8'h84, "if0", 32'hedcb_a987);
		rdc(8'h88, "if1", 32'h0000_10fe);
		rdc(8'h80, "status", 32'h4433_2211);
		rdc(ADDR_UNIT_LO, "unit", 32'h0);
		wr(ADDR_CMD, 32'h0000_5004);
		rdc(ADDR_CMD, "ignored", 32'h0);
		err_mask <= 8'h01;
		cmd(32'h0000_1003);
		rdc(ADDR_FAULT, "fault", 32'h3);
	endtask

	task automatic t_setup;
		logic [7:0] code;
		logic [15:0] a;
		slow <= 1'b1;
		err_mask <= 8'h00;
		cmd(32'h0000_0800);
		cmd(32'h0000_0f01);
		rdc(ADDR_FAULT, "fault", 32'h0);
		rdc(8'h8c, "pointer", 32'h0000_0100);
		for (int i = 0; i < 8; i++) begin
			code = ((i < 4) ? 8'h44 : 8'h64) + 8'(i % 4);
			a = 16'h0100 + 16'(2 * i);
			wr(8'h84, 32'hffff_ffff);
			wr(8'h80, {code, 8'h00, a});
			cmd(32'h0000_1001);
			rdc(ADDR_FAULT, "fault", 32'h0);
			rdc(8'h84, "param", {a, ~a} & wmask(code[1:0]));
		end
		wr(8'h80, 32'h5000_0123);
		cmd(32'h0000_1001);
		rdc(ADDR_FAULT, "badcode", 32'h1);
		err_mask <= 8'h01;
		wr(8'h80, 32'h6500_0002);
		cmd(32'h0000_1001);
		rdc(ADDR_FAULT, "remote", 32'h1);
	endtask

	initial begin
		resetn = 1'b0;
		slow = 1'b0;
		err_mask = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		t_idle();
		t_start();
		t_trigger();
		t_setup();
		conclude();
	end
endmodule // shs_sequencer_bench
`default_nettype wire
